// File: verilog/crsv_regs.vh
// Constants for the core regulator start-up sequencer and voltage-code decoder
`ifndef CRSV_REGS_VH
`define CRSV_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CRSV_OFS_CTRL 8'h00
`define CRSV_OFS_STATUS 8'h04
`define CRSV_OFS_LEVEL 8'h08
`define CRSV_OFS_IRQ_STATUS 8'h0c
`define CRSV_OFS_IRQ_ENABLE 8'h10
`define CRSV_OFS_IRQ_CLEAR 8'h14

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CRSV_CTRL_RESET 1'h1
`define CRSV_IRQ_W 3
`define CRSV_IRQ_CLKEN 0
`define CRSV_IRQ_POWER_GOOD_OUT 1
`define CRSV_IRQ_ABORT 2

// ----------------------------------------------------------------------------
// Voltage levels in 0.5 mV units
// ----------------------------------------------------------------------------
`define CRSV_LVL_W 12
`define CRSV_LVL_TOP 12'hbb8
`define CRSV_LVL_STEP 12'h019
`define CRSV_LVL_BOOT 12'h960
`define CRSV_LVL_TOL 12'h028
`define CRSV_LVL_ZERO 12'h000
`define CRSV_CODE_LAST 7'h77
`define CRSV_SLEW_SOFT 12'h004
`define CRSV_SLEW_FAST 12'h014

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CRSV_CLK_MHZ 25
`define CRSV_START_DELAY_US 100
`define CRSV_START_CYCLES (`CRSV_START_DELAY_US * `CRSV_CLK_MHZ)
`define CRSV_SETTLE_CYCLES 13
`define CRSV_PG_DELAY_US 6800
`define CRSV_PG_CYCLES (`CRSV_PG_DELAY_US * `CRSV_CLK_MHZ)
`define CRSV_TMR_W 18

`endif

// File: verilog/crsv_ramp.v
// Slew-limited reference level that steps toward a target on each tick
`timescale 1ns/10ps
`default_nettype none
`include "crsv_regs.vh"

module crsv_ramp #(
  parameter W = `CRSV_LVL_W
) (
  input wire clock_in,
  input wire nrst_in,
  input wire clear_in,
  input wire tick_in,
  input wire [W-1:0] step_in,
  input wire [W-1:0] target_in,
  output reg [W-1:0] level_out
);

  // ----------------------------------------------------------------------------
  // Ramp
  // ----------------------------------------------------------------------------
  // Clamp the last step so the level lands exactly on the target
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_out <= {W{1'b0}};
    end else if (clear_in) begin
      level_out <= {W{1'b0}};
    end else if (tick_in) begin
      if (level_out < target_in) begin
        if (target_in - level_out > step_in) begin
          level_out <= level_out + step_in;
        end else begin
          level_out <= target_in;
        end
      end else if (level_out > target_in) begin
        if (level_out - target_in > step_in) begin
          level_out <= level_out - step_in;
        end else begin
          level_out <= target_in;
        end
      end
    end
  end

endmodule // crsv_ramp
`default_nettype wire

// File: verilog/crsv_top.v
// Start-up sequencer, voltage-code decoder and register slave of the core regulator
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "crsv_regs.vh"

// Notes on behaviour
// - With the CTRL enable bit set, a rising regulator enable starts the start-up sequence.
// - About 100 us later the reference ramps toward the 1.2 V boot level.
// - Continuous conduction is forced and mode requests ignored until start-up ends.
// - Within 20 mV of boot, 13 clock cycles are counted, then clock-enable goes low.
// - After clock-enable the reference slews fast (10 mV/us) to the code's target.
// - Power good rises roughly 7 ms after the move to the code's target begins.
// - After start-up the output tracks the live value of the 7-bit voltage code.
// - Code zero selects 1.5000 V and each increment lowers the target 12.5 mV.
// - The power-good delay runs from clock-enable assertion, 6.8 ms typical.
module crsv_top #(
  parameter [`CRSV_TMR_W-1:0] PG_CYCLES = `CRSV_PG_CYCLES
) (
  input wire clock_in,
  input wire nrst_in,
  input wire regulator_enable_in,
  input wire [6:0] voltage_code_in,
  input wire mode_request_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg clock_enable_n_out,
  output reg power_good_out,
  output reg forced_continuous_conduction_out,
  output wire [`CRSV_LVL_W-1:0] regulated_output_out,
  output reg irq_out
);

  // ----------------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h3;
  localparam [2:0] ST_SLEW = 3'h4;
  localparam [2:0] ST_RUN = 3'h5;

  // Timer loads; the counts are cut to the timer width on purpose
  localparam [31:0] START_LOAD = `CRSV_START_CYCLES - 1;
  localparam [31:0] SETTLE_LOAD = `CRSV_SETTLE_CYCLES - 1;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CRSV_TMR_W-1:0] timer;
  reg [`CRSV_TMR_W-1:0] next_timer;
  reg [4:0] us_div;
  reg us_tick;
  reg seq_enable;
  reg enable_d;
  reg [`CRSV_IRQ_W-1:0] irq_status;
  reg [`CRSV_IRQ_W-1:0] irq_enable;
  reg [`CRSV_IRQ_W-1:0] next_irq_status;
  reg [`CRSV_LVL_W-1:0] code_level;
  reg [`CRSV_LVL_W-1:0] ramp_target;
  reg [`CRSV_LVL_W-1:0] ramp_step;
  reg [`CRSV_LVL_W-1:0] boot_gap;
  wire [`CRSV_LVL_W-1:0] level;
  wire enabled;
  wire start_edge;
  wire bus_req;
  wire bus_take;
  wire [`CRSV_IRQ_W-1:0] irq_event;
  wire irq_clear_hit;

  assign enabled = regulator_enable_in & seq_enable;
  assign start_edge = enabled & ~enable_d;
  assign regulated_output_out = level;

  // ----------------------------------------------------------------------------
  // Voltage-code decode
  // ----------------------------------------------------------------------------
  // Codes past the last step read as zero volts
  always @* begin
    if (voltage_code_in > `CRSV_CODE_LAST) begin
      code_level = `CRSV_LVL_ZERO;
    end else begin
      code_level = `CRSV_LVL_TOP - voltage_code_in * `CRSV_LVL_STEP;
    end
  end

  // Distance of the reference from the boot level
  always @* begin
    if (level > `CRSV_LVL_BOOT) begin
      boot_gap = level - `CRSV_LVL_BOOT;
    end else begin
      boot_gap = `CRSV_LVL_BOOT - level;
    end
  end

  // ----------------------------------------------------------------------------
  // Microsecond tick for the slew
  // ----------------------------------------------------------------------------
  // Divide the clock by its megahertz count for a one-cycle pulse each microsecond
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      us_div <= 5'h00;
      us_tick <= 1'b0;
    end else if (us_div == `CRSV_CLK_MHZ - 1) begin
      us_div <= 5'h00;
      us_tick <= 1'b1;
    end else begin
      us_div <= us_div + 5'h01;
      us_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // One timer serves the start delay, the settle count and the power-good delay
  always @* begin
    next_state = state;
    next_timer = timer;
    ramp_target = `CRSV_LVL_BOOT;
    ramp_step = `CRSV_SLEW_SOFT;
    case (state)
      ST_IDLE: begin
        ramp_target = `CRSV_LVL_ZERO;
        if (start_edge) begin
          next_state = ST_DELAY;
          next_timer = START_LOAD[`CRSV_TMR_W-1:0];
        end
      end
      ST_DELAY: begin
        ramp_target = `CRSV_LVL_ZERO;
        if (timer == {`CRSV_TMR_W{1'b0}}) begin
          next_state = ST_SOFT;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      ST_SOFT: begin
        // Tolerance is judged on the digital reference, not on a sensed output
        if (boot_gap <= `CRSV_LVL_TOL) begin
          next_state = ST_SETTLE;
          next_timer = SETTLE_LOAD[`CRSV_TMR_W-1:0];
        end
      end
      ST_SETTLE: begin
        if (timer == {`CRSV_TMR_W{1'b0}}) begin
          next_state = ST_SLEW;
          next_timer = PG_CYCLES - 1'b1;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      ST_SLEW: begin
        // Power-good delay runs from clock-enable, not from reaching the target
        ramp_target = code_level;
        ramp_step = `CRSV_SLEW_FAST;
        if (timer == {`CRSV_TMR_W{1'b0}}) begin
          next_state = ST_RUN;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      ST_RUN: begin
        ramp_target = code_level;
        ramp_step = `CRSV_SLEW_FAST;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Losing enable anywhere aborts back to idle
    if (!enabled) begin
      next_state = ST_IDLE;
      next_timer = {`CRSV_TMR_W{1'b0}};
    end
  end

  // State, timer and enable history for the start edge
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      timer <= {`CRSV_TMR_W{1'b0}};
      enable_d <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      enable_d <= enabled;
    end
  end

  // Pin outputs are registered from the next state so they change with the state and come from flops
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clock_enable_n_out <= 1'b1;
      power_good_out <= 1'b0;
    end else begin
      clock_enable_n_out <= ~(next_state == ST_SLEW || next_state == ST_RUN);
      power_good_out <= (next_state == ST_RUN);
    end
  end

  // ----------------------------------------------------------------------------
  // Conduction mode
  // ----------------------------------------------------------------------------
  // Mode request only honoured once start-up is complete; a restart forces it again
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      forced_continuous_conduction_out <= 1'b1;
    end else begin
      forced_continuous_conduction_out <= (next_state != ST_RUN) | ~mode_request_in;
    end
  end

  // Reference ramp; held at zero while idle so a restart ramps from scratch
  crsv_ramp #(
    .W(`CRSV_LVL_W)
  ) u_ramp (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clear_in(state == ST_IDLE || state == ST_DELAY),
    .tick_in(us_tick),
    .step_in(ramp_step),
    .target_in(ramp_target),
    .level_out(level)
  );

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  assign irq_event[`CRSV_IRQ_CLKEN] = (state == ST_SETTLE) && (next_state == ST_SLEW);
  assign irq_event[`CRSV_IRQ_POWER_GOOD_OUT] = (state == ST_SLEW) && (next_state == ST_RUN);
  assign irq_event[`CRSV_IRQ_ABORT] = (state != ST_IDLE) && !enabled;

  assign irq_clear_hit = bus_take && avs_write_in && (avs_address_in == `CRSV_OFS_IRQ_CLEAR);

  // A new event outranks a clear in the same cycle
  always @* begin
    if (irq_clear_hit) begin
      next_irq_status = (irq_status & ~avs_writedata_in[`CRSV_IRQ_W-1:0]) | irq_event;
    end else begin
      next_irq_status = irq_status | irq_event;
    end
  end

  // The line follows the status it is about to hold, so a clear drops it at once
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= {`CRSV_IRQ_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out <= |(next_irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------------
  // Two-cycle answer: data is latched in the first, waitrequest drops for the second
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_take = bus_req & ~avs_waitrequest_out;

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (bus_req && avs_waitrequest_out && avs_read_in) begin
        case (avs_address_in)
          `CRSV_OFS_CTRL: avs_readdata_out <= {31'h0000_0000, seq_enable};
          `CRSV_OFS_STATUS: avs_readdata_out <= {25'h000_0000, state,
            forced_continuous_conduction_out, power_good_out, clock_enable_n_out, enabled};
          `CRSV_OFS_LEVEL: avs_readdata_out <= {4'h0, code_level, 4'h0, level};
          `CRSV_OFS_IRQ_STATUS: avs_readdata_out <= {29'h0000_0000, irq_status};
          `CRSV_OFS_IRQ_ENABLE: avs_readdata_out <= {29'h0000_0000, irq_enable};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable registers
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_enable <= `CRSV_CTRL_RESET;
      irq_enable <= {`CRSV_IRQ_W{1'b0}};
    end else if (bus_take && avs_write_in) begin
      if (avs_address_in == `CRSV_OFS_CTRL) begin
        seq_enable <= avs_writedata_in[0];
      end
      if (avs_address_in == `CRSV_OFS_IRQ_ENABLE) begin
        irq_enable <= avs_writedata_in[`CRSV_IRQ_W-1:0];
      end
    end
  end

endmodule // crsv_top
`default_nettype wire

// File: test/crsv_monitor.sv
// Port checker for the start-up sequencer
`timescale 1ns/10ps
`default_nettype none
`include "crsv_regs.vh"
module crsv_monitor #(
  parameter [`CRSV_TMR_W-1:0] PG_CYCLES = `CRSV_PG_CYCLES
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic regulator_enable_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic clock_enable_n_out,
  input wire logic power_good_out,
  input wire logic forced_continuous_conduction_out,
  input wire logic [11:0] regulated_output_out
);
  logic [`CRSV_TMR_W-1:0] pg_cnt;
  // Cycles with clock enable low; saturates so a long run never wraps
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) pg_cnt <= '0;
    else if (clock_enable_n_out) pg_cnt <= '0;
    else if (pg_cnt != '1) pg_cnt <= pg_cnt + 1'b1;
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  a_pg_needs_clken: assert property (power_good_out |-> !clock_enable_n_out)
    else $error("power good while clock enable off");
  a_pg_delay_count: assert property ($rose(power_good_out) |->
    pg_cnt >= PG_CYCLES - 2 && pg_cnt <= PG_CYCLES + 2)
    else $error("power good delay wrong");
  a_clken_near_boot: assert property ($fell(clock_enable_n_out) |->
    regulated_output_out >= 12'h924 && regulated_output_out <= 12'h99c)
    else $error("clock enable far from boot level");
  a_forced_in_start: assert property (
    regulator_enable_in && !power_good_out |-> forced_continuous_conduction_out)
    else $error("conduction mode left during start");
  a_idle_on_drop: assert property ($fell(regulator_enable_in) |->
    ##[1:2] (clock_enable_n_out && !power_good_out))
    else $error("outputs not idle after enable drop");
  a_level_cleared: assert property ($fell(regulator_enable_in) |->
    ##3 (regulated_output_out == 12'h000))
    else $error("level not cleared");
  a_slew_limit: assert property (regulator_enable_in && $past(regulator_enable_in) |->
    (regulated_output_out - $past(regulated_output_out) + 12'h014) <= 12'h028)
    else $error("level step too large");
  a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |-> ##[1:2] !avs_waitrequest_out)
    else $error("bus answer late");
  a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
endmodule // crsv_monitor
bind crsv_top crsv_monitor #(.PG_CYCLES(PG_CYCLES)) u_mon (
  .clock_in(clock_in), .nrst_in(nrst_in), .regulator_enable_in(regulator_enable_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .clock_enable_n_out(clock_enable_n_out),
  .power_good_out(power_good_out),
  .forced_continuous_conduction_out(forced_continuous_conduction_out),
  .regulated_output_out(regulated_output_out));
`default_nettype wire

// File: test/crsv_host_model.sv
// Host-side model driving enable, voltage code and mode request
`timescale 1ns/10ps
`default_nettype none
module crsv_host_model (
  input wire logic clock_in,
  input wire logic clock_enable_n_in,
  input wire logic power_good_in,
  output logic regulator_enable_out,
  output logic [6:0] voltage_code_out,
  output logic mode_request_out
);
  initial begin
    regulator_enable_out = 1'b0;
    voltage_code_out = 7'h00;
  end
  // Host asks for low power early on purpose; the regulator must hold off
  always @(posedge clock_in) begin
    mode_request_out <= regulator_enable_out & (clock_enable_n_in | power_good_in);
  end
  task automatic power(input logic on);
    @(posedge clock_in);
    regulator_enable_out <= on;
  endtask
  task automatic set_code(input logic [6:0] c);
    @(posedge clock_in);
    voltage_code_out <= c;
  endtask
endmodule // crsv_host_model
`default_nettype wire

// File: test/crsv_top_test.sv
// Self-checking bench of the start-up sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
`define WAIT_FOR(c, lim) begin \
  n = 0; \
  while (!(c) && n < lim) begin \
    @(posedge clock_in); \
    n++; \
  end \
end
module crsv_top_test;
  logic clock_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic clock_enable_n_out, power_good_out, forced_continuous_conduction_out;
  logic irq_out, regulator_enable_in, mode_request_in;
  logic [6:0] voltage_code_in;
  logic [7:0] avs_address_in;
  logic [11:0] regulated_output_out, lvl;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [6:0] codes [4] = '{7'h00, 7'h01, 7'h77, 7'h78};
  int num_errors = 0;
  int n_compared = 0;
  int n;
  crsv_top #(.PG_CYCLES(18'h000c8)) u_dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .regulator_enable_in(regulator_enable_in),
    .voltage_code_in(voltage_code_in), .mode_request_in(mode_request_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .clock_enable_n_out(clock_enable_n_out), .power_good_out(power_good_out),
    .forced_continuous_conduction_out(forced_continuous_conduction_out),
    .regulated_output_out(regulated_output_out), .irq_out(irq_out));
  crsv_host_model u_host (
    .clock_in(clock_in), .clock_enable_n_in(clock_enable_n_out),
    .power_good_in(power_good_out), .regulator_enable_out(regulator_enable_in),
    .voltage_code_out(voltage_code_in), .mode_request_out(mode_request_in));
  always #20 clock_in = ~clock_in;
  // One access; the idle edge first keeps strobes from being set twice at one edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0 && k < 16) begin
      @(posedge clock_in);
      k++;
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (k == 16) num_errors++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHECK($sformatf("reg %h", a), e, q)
  endtask
  function automatic logic [11:0] code_level(input logic [6:0] c);
    return (c >= 7'h78) ? 12'h000 : 12'hbb8 - 12'h019 * {5'h0, c};
  endfunction
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Run is near 45k cycles; twice that means a hang
  initial begin
    repeat (90000) @(posedge clock_in);
    num_errors++;
    print_verdict();
  end
  // Main sequence: registers, full start, code sweep, abort, gated restart
  initial begin
    clock_in = 1'b0;
    nrst_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 8'h00;
    avs_writedata_in = 32'h0;
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'ha);
    rd(8'h0c, 32'h0);
    rd(8'h14, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    bus(1'b1, 8'h10, 32'h7);
    rd(8'h10, 32'h7);
    u_host.set_code(7'h29);
    u_host.power(1'b1);
    `WAIT_FOR(regulated_output_out !== 12'h000, 4000)
    `CHECK("start delay", 1'b1, n >= 2495 && n <= 2530)
    `WAIT_FOR(clock_enable_n_out === 1'b0, 20000)
    `CHECK("forced", 1'b1, forced_continuous_conduction_out)
    `CHECK("clken", 1'b0, clock_enable_n_out)
    `WAIT_FOR(power_good_out === 1'b1, 400)
    `CHECK("pg delay", 1'b1, n >= 197 && n <= 202)
    `WAIT_FOR(regulated_output_out === 12'h7b7, 1000)
    `CHECK("fast slew", 1'b1, n < 400)
    rd(8'h08, 32'h07b707b7);
    `CHECK("forced off", 1'b0, forced_continuous_conduction_out)
    rd(8'h04, 32'h55);
    foreach (codes[i]) begin
      lvl = code_level(codes[i]);
      u_host.set_code(codes[i]);
      `WAIT_FOR(regulated_output_out === lvl, 5000)
      rd(8'h08, {4'h0, lvl, 4'h0, lvl});
    end
    rd(8'h0c, 32'h3);
    `CHECK("irq", 1'b1, irq_out)
    bus(1'b1, 8'h14, 32'h7);
    rd(8'h0c, 32'h0);
    `CHECK("irq", 1'b0, irq_out)
    u_host.power(1'b0);
    repeat (3) @(posedge clock_in);
    `CHECK("clken off", 1'b1, clock_enable_n_out)
    `CHECK("pg off", 1'b0, power_good_out)
    rd(8'h0c, 32'h4);
    bus(1'b1, 8'h10, 32'h0);
    rd(8'h0c, 32'h4);
    `CHECK("irq masked", 1'b0, irq_out)
    bus(1'b1, 8'h14, 32'h7);
    bus(1'b1, 8'h00, 32'h0);
    u_host.power(1'b1);
    repeat (3000) @(posedge clock_in);
    `CHECK("gated", 12'h000, regulated_output_out)
    bus(1'b1, 8'h00, 32'h1);
    `WAIT_FOR(clock_enable_n_out === 1'b0, 20000)
    `CHECK("restart", 1'b0, clock_enable_n_out)
    print_verdict();
  end
endmodule // crsv_top_test
`default_nettype wire
